// ---- common/plb_pkg.sv ----
package plb_pkg;
	// ****************************************
	// array dimensions
	// ****************************************
	localparam int PLB_NUM_MC = 16;
	localparam int PLB_HALF_MC = 8;
	localparam int PLB_NUM_GIM = 36;
	localparam int PLB_NUM_PT = 86;
	localparam int PLB_NUM_GEN_PT = 80;
	localparam int PLB_PT_OE_BASE = 80;
	localparam int PLB_PT_ASET = 84;
	localparam int PLB_PT_ARST = 85;
	localparam int PLB_STEER_W = 16;
	localparam int PLB_STEER_STRIDE = 5;
	localparam int PLB_NUM_ICLK = 4;
	localparam int PLB_NUM_DED = 2;
	localparam int PLB_NUM_INCELL = 6;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [11:0] PLB_PT_END = 12'h560;
	localparam logic [11:0] PLB_MC_BASE = 12'h600;
	localparam logic [11:0] PLB_IN_BASE = 12'h640;
	localparam logic [11:0] PLB_CTRL = 12'h660;
	localparam logic [11:0] PLB_STAT = 12'h664;
	localparam logic [2:0] PLB_IN_CNT = 3'h6;

	// product term words: true low, true high, inverted low, inverted high
	localparam logic [1:0] PLB_PT_TRUE_LO = 2'h0;
	localparam logic [1:0] PLB_PT_TRUE_HI = 2'h1;
	localparam logic [1:0] PLB_PT_COMP_LO = 2'h2;
	localparam logic [1:0] PLB_PT_COMP_HI = 2'h3;

	// macrocell / io cell configuration word
	localparam int PLB_MC_CFG_W = 24;
	localparam int PLB_MC_STEER_LSB = 0;
	localparam int PLB_MC_MODE_LSB = 16;
	localparam int PLB_MC_CLK_LSB = 18;
	localparam int PLB_MC_INV_BIT = 20;
	localparam int PLB_MC_INREG_BIT = 21;
	localparam int PLB_MC_OE_LSB = 22;

	// input cell configuration word
	localparam int PLB_IN_CFG_W = 4;
	localparam int PLB_IN_MODE_LSB = 0;
	localparam int PLB_IN_CLK_LSB = 2;

	// block control word
	localparam int PLB_CTRL_W = 10;
	localparam int PLB_CTRL_SETPOL_BIT = 0;
	localparam int PLB_CTRL_RSTPOL_BIT = 1;
	localparam int PLB_CTRL_MCPOL_LSB = 2;
	localparam int PLB_CTRL_INPOL_LSB = 6;

	// reset values
	localparam logic [PLB_MC_CFG_W-1:0] PLB_MC_CFG_RST = 24'h0;
	localparam logic [PLB_IN_CFG_W-1:0] PLB_IN_CFG_RST = 4'h0;
	localparam logic [PLB_CTRL_W-1:0] PLB_CTRL_RST = 10'h0;

	// ****************************************
	// modes
	// ****************************************
	typedef enum logic [1:0] {
		PLB_MC_COMB = 2'b00,
		PLB_MC_DFF = 2'b01,
		PLB_MC_TFF = 2'b10,
		PLB_MC_LATCH = 2'b11
	} plb_mode_e;

	typedef enum logic [1:0] {
		PLB_IN_COMB = 2'b00,
		PLB_IN_REG = 2'b01,
		PLB_IN_DREG = 2'b10,
		PLB_IN_LATCH = 2'b11
	} plb_inmode_e;

	typedef enum logic [1:0] {
		PLB_OE_OFF = 2'b00,
		PLB_OE_ON = 2'b01,
		PLB_OE_PT_A = 2'b10,
		PLB_OE_PT_B = 2'b11
	} plb_oe_e;
endpackage : plb_pkg

// ---- rtl/plb_macrocell.sv ----
module plb_macrocell (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic d_in,
	input wire plb_pkg::plb_mode_e mode,
	input wire logic clk_edge,
	input wire logic clk_open,
	input wire logic aset,
	input wire logic arst,
	input wire logic inv,
	output logic fb_out,
	output logic pin_out
);
	import plb_pkg::*;

	logic q_r;
	logic q_nxt;
	logic value;

	// ****************************************
	// storage element
	// ****************************************
	always_comb begin
		q_nxt = q_r;
		unique case (mode)
			PLB_MC_COMB: q_nxt = d_in;
			PLB_MC_DFF: if (clk_edge) q_nxt = d_in;
			PLB_MC_TFF: if (clk_edge) q_nxt = q_r ^ d_in;
			PLB_MC_LATCH: if (clk_open) q_nxt = d_in;
		endcase
		// reset term wins over set term
		if (arst) begin
			q_nxt = 1'b0;
		end else if (aset) begin
			q_nxt = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r <= 1'b0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// set/reset override the output at once, not at the next edge
	always_comb begin
		if (arst) begin
			value = 1'b0;
		end else if (aset) begin
			value = 1'b1;
		end else if (mode == PLB_MC_COMB || (mode == PLB_MC_LATCH && clk_open)) begin
			value = d_in;
		end else begin
			value = q_r;
		end
	end

	assign fb_out = value;
	assign pin_out = value ^ inv;
endmodule : plb_macrocell

// ---- rtl/plb_logic_block.sv ----
// Local design decisions: the address map and the APB slave port.
module plb_logic_block #(
	parameter bit REG_INTENSIVE = 1'b0,
	parameter bit FOUR_CLOCKS = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [plb_pkg::PLB_NUM_GIM-1:0] gim_in,
	input wire logic [plb_pkg::PLB_NUM_MC-1:0] io_in,
	output logic [plb_pkg::PLB_NUM_MC-1:0] io_out,
	output logic [plb_pkg::PLB_NUM_MC-1:0] io_oe,
	input wire logic [plb_pkg::PLB_NUM_DED-1:0] ded_pin,
	input wire logic [plb_pkg::PLB_NUM_ICLK-1:0] ic_pin,
	output logic [plb_pkg::PLB_NUM_ICLK-1:0] gclk_out,
	output logic [plb_pkg::PLB_NUM_MC-1:0] mc_to_gim,
	output logic [plb_pkg::PLB_NUM_MC-1:0] pin_to_gim,
	output logic [plb_pkg::PLB_NUM_INCELL-1:0] in_to_gim
);
	import plb_pkg::*;

	// ****************************************
	// configuration storage
	// ****************************************
	logic [PLB_NUM_GIM-1:0] pt_true_r [PLB_NUM_PT];
	logic [PLB_NUM_GIM-1:0] pt_true_nxt [PLB_NUM_PT];
	logic [PLB_NUM_GIM-1:0] pt_comp_r [PLB_NUM_PT];
	logic [PLB_NUM_GIM-1:0] pt_comp_nxt [PLB_NUM_PT];
	logic [PLB_MC_CFG_W-1:0] mc_cfg_r [PLB_NUM_MC];
	logic [PLB_MC_CFG_W-1:0] mc_cfg_nxt [PLB_NUM_MC];
	logic [PLB_IN_CFG_W-1:0] in_cfg_r [PLB_NUM_INCELL];
	logic [PLB_IN_CFG_W-1:0] in_cfg_nxt [PLB_NUM_INCELL];
	logic [PLB_CTRL_W-1:0] ctrl_r;
	logic [PLB_CTRL_W-1:0] ctrl_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;

	// ****************************************
	// bus decode
	// ****************************************
	logic wr_en;
	logic aligned;
	logic pt_hit;
	logic mc_hit;
	logic in_hit;
	logic ctrl_hit;
	logic stat_hit;
	logic [6:0] pt_term;
	logic [1:0] pt_word;
	logic [3:0] mc_idx;
	logic [2:0] in_idx;
	logic [31:0] rd_val;
	logic [31:0] stat_val;

	// block state
	logic [PLB_NUM_PT-1:0] pt;
	logic aset;
	logic arst;
	logic [PLB_NUM_ICLK-1:0] clk_present;
	logic [PLB_NUM_ICLK-1:0] ic_prev_r;
	logic [PLB_NUM_ICLK-1:0] ic_rise;
	logic [PLB_NUM_ICLK-1:0] ic_fall;
	logic [PLB_NUM_ICLK-1:0] mc_edge;
	logic [PLB_NUM_ICLK-1:0] mc_open;
	logic [PLB_NUM_ICLK-1:0] in_edge;
	logic [PLB_NUM_ICLK-1:0] in_open;
	logic [PLB_NUM_INCELL-1:0] in_src;

	assign wr_en = psel & penable & pwrite;
	assign aligned = (paddr[1:0] == 2'h0);
	assign pt_term = paddr[10:4];
	assign pt_word = paddr[3:2];
	assign mc_idx = paddr[5:2];
	assign in_idx = paddr[4:2];
	assign pt_hit = aligned && (paddr < PLB_PT_END);
	assign mc_hit = aligned && (paddr[11:6] == PLB_MC_BASE[11:6]);
	assign in_hit = aligned && (paddr[11:5] == PLB_IN_BASE[11:5]) && (in_idx < PLB_IN_CNT);
	assign ctrl_hit = (paddr == PLB_CTRL);
	assign stat_hit = (paddr == PLB_STAT);

	// ****************************************
	// product term array writes
	// ****************************************
	always_comb begin
		pt_true_nxt = pt_true_r;
		pt_comp_nxt = pt_comp_r;
		if (wr_en && pt_hit) begin
			unique case (pt_word)
				PLB_PT_TRUE_LO: pt_true_nxt[pt_term][31:0] = pwdata;
				PLB_PT_TRUE_HI: pt_true_nxt[pt_term][PLB_NUM_GIM-1:32] = pwdata[3:0];
				PLB_PT_COMP_LO: pt_comp_nxt[pt_term][31:0] = pwdata;
				PLB_PT_COMP_HI: pt_comp_nxt[pt_term][PLB_NUM_GIM-1:32] = pwdata[3:0];
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int t = 0; t < PLB_NUM_PT; t++) begin
				pt_true_r[t] <= '0;
				pt_comp_r[t] <= '0;
			end
		end else begin
			pt_true_r <= pt_true_nxt;
			pt_comp_r <= pt_comp_nxt;
		end
	end

	// ****************************************
	// cell and control writes
	// ****************************************
	// config is meant to be loaded once; changing it live is legal but glitchy
	always_comb begin
		mc_cfg_nxt = mc_cfg_r;
		in_cfg_nxt = in_cfg_r;
		ctrl_nxt = ctrl_r;
		if (wr_en && mc_hit) begin
			mc_cfg_nxt[mc_idx] = pwdata[PLB_MC_CFG_W-1:0];
		end
		if (wr_en && in_hit) begin
			in_cfg_nxt[in_idx] = pwdata[PLB_IN_CFG_W-1:0];
		end
		if (wr_en && ctrl_hit) begin
			ctrl_nxt = pwdata[PLB_CTRL_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int m = 0; m < PLB_NUM_MC; m++) begin
				mc_cfg_r[m] <= PLB_MC_CFG_RST;
			end
			for (int n = 0; n < PLB_NUM_INCELL; n++) begin
				in_cfg_r[n] <= PLB_IN_CFG_RST;
			end
			ctrl_r <= PLB_CTRL_RST;
		end else begin
			mc_cfg_r <= mc_cfg_nxt;
			in_cfg_r <= in_cfg_nxt;
			ctrl_r <= ctrl_nxt;
		end
	end

	// ****************************************
	// read path
	// ****************************************
	assign stat_val = {8'h0, arst, aset, in_to_gim, mc_to_gim};

	always_comb begin
		rd_val = 32'h0;
		if (pt_hit) begin
			unique case (pt_word)
				PLB_PT_TRUE_LO: rd_val = pt_true_r[pt_term][31:0];
				PLB_PT_TRUE_HI: rd_val = {28'h0, pt_true_r[pt_term][PLB_NUM_GIM-1:32]};
				PLB_PT_COMP_LO: rd_val = pt_comp_r[pt_term][31:0];
				PLB_PT_COMP_HI: rd_val = {28'h0, pt_comp_r[pt_term][PLB_NUM_GIM-1:32]};
			endcase
		end else if (mc_hit) begin
			rd_val = {8'h0, mc_cfg_r[mc_idx]};
		end else if (in_hit) begin
			rd_val = {28'h0, in_cfg_r[in_idx]};
		end else if (ctrl_hit) begin
			rd_val = {22'h0, ctrl_r};
		end else if (stat_hit) begin
			rd_val = stat_val;
		end
	end

	// answer is prepared in the setup cycle so prdata comes from a flop
	always_comb begin
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		if (psel && !penable) begin
			prdata_nxt = pwrite ? 32'h0 : rd_val;
			pslverr_nxt = !(pt_hit || mc_hit || in_hit || ctrl_hit || (stat_hit && !pwrite));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = 1'b1;
	assign pslverr = psel & penable & pslverr_r;

	// ****************************************
	// product term array
	// ****************************************
	// an empty term reads as false so unused terms never fire
	for (genvar t = 0; t < PLB_NUM_PT; t++) begin : g_pt
		logic used;
		logic match;
		assign used = (|pt_true_r[t]) | (|pt_comp_r[t]);
		assign match = ~|(pt_true_r[t] & ~gim_in) & ~|(pt_comp_r[t] & gim_in);
		assign pt[t] = used & match;
	end

	// inverting an empty term asserts it permanently; keep polarity 0 when unused
	assign aset = pt[PLB_PT_ASET] ^ ctrl_r[PLB_CTRL_SETPOL_BIT];
	assign arst = pt[PLB_PT_ARST] ^ ctrl_r[PLB_CTRL_RSTPOL_BIT];

	// ****************************************
	// clock distribution
	// ****************************************
	assign clk_present = FOUR_CLOCKS ? 4'hf : 4'h3;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ic_prev_r <= '0;
		end else begin
			ic_prev_r <= ic_pin;
		end
	end

	assign ic_rise = ic_pin & ~ic_prev_r & clk_present;
	assign ic_fall = ~ic_pin & ic_prev_r & clk_present;
	assign gclk_out = ic_pin & clk_present;

	for (genvar k = 0; k < PLB_NUM_ICLK; k++) begin : g_clk
		logic mc_pol;
		logic in_pol;
		assign mc_pol = ctrl_r[PLB_CTRL_MCPOL_LSB + k];
		assign in_pol = ctrl_r[PLB_CTRL_INPOL_LSB + k];
		assign mc_edge[k] = mc_pol ? ic_fall[k] : ic_rise[k];
		assign mc_open[k] = clk_present[k] & (mc_pol ? ~ic_pin[k] : ic_pin[k]);
		assign in_edge[k] = in_pol ? ic_fall[k] : ic_rise[k];
		assign in_open[k] = clk_present[k] & (in_pol ? ~ic_pin[k] : ic_pin[k]);
	end

	// ****************************************
	// allocator, macrocells and io cells
	// ****************************************
	// windows of 16 terms at a stride of 5 overlap, so a term is reachable
	// from up to six neighbouring macrocells; delay is the same either way
	for (genvar i = 0; i < PLB_NUM_MC; i++) begin : g_mc
		localparam int WBASE = (PLB_STEER_STRIDE * i > PLB_NUM_GEN_PT - PLB_STEER_W) ?
			PLB_NUM_GEN_PT - PLB_STEER_W : PLB_STEER_STRIDE * i;
		localparam int OE_A = PLB_PT_OE_BASE + 2 * (i / PLB_HALF_MC);
		localparam bit IS_IO = !REG_INTENSIVE || (i % 2 == 0);
		localparam bit IS_BURIED = !IS_IO;
		logic [PLB_STEER_W-1:0] steer;
		logic [1:0] clk_sel;
		logic sum;
		logic d_src;
		logic fb;
		logic pin_val;
		logic dyn_oe;

		assign steer = mc_cfg_r[i][PLB_MC_STEER_LSB +: PLB_STEER_W];
		assign clk_sel = mc_cfg_r[i][PLB_MC_CLK_LSB +: 2];
		assign sum = |(pt[WBASE +: PLB_STEER_W] & steer);

		if (IS_BURIED) begin : g_inreg
			assign d_src = mc_cfg_r[i][PLB_MC_INREG_BIT] ? io_in[i-1] : sum;
		end else begin : g_logic
			assign d_src = sum;
		end

		plb_macrocell u_mc (
			.pclk(pclk),
			.presetn(presetn),
			.d_in(d_src),
			.mode(plb_mode_e'(mc_cfg_r[i][PLB_MC_MODE_LSB +: 2])),
			.clk_edge(mc_edge[clk_sel]),
			.clk_open(mc_open[clk_sel]),
			.aset(aset),
			.arst(arst),
			.inv(mc_cfg_r[i][PLB_MC_INV_BIT]),
			.fb_out(fb),
			.pin_out(pin_val)
		);

		assign mc_to_gim[i] = fb;
		assign pin_to_gim[i] = IS_IO & io_in[i];

		always_comb begin
			unique case (plb_oe_e'(mc_cfg_r[i][PLB_MC_OE_LSB +: 2]))
				PLB_OE_OFF: dyn_oe = 1'b0;
				PLB_OE_ON: dyn_oe = 1'b1;
				PLB_OE_PT_A: dyn_oe = pt[OE_A];
				PLB_OE_PT_B: dyn_oe = pt[OE_A + 1];
			endcase
		end

		assign io_oe[i] = IS_IO & dyn_oe;
		assign io_out[i] = IS_IO & pin_val;
	end

	// ****************************************
	// dedicated input and input/clock cells
	// ****************************************
	assign in_src = {ic_pin, ded_pin};

	for (genvar j = 0; j < PLB_NUM_INCELL; j++) begin : g_in
		plb_inmode_e mode;
		logic [1:0] csel;
		logic s1_r;
		logic s1_nxt;
		logic s2_r;
		logic s2_nxt;
		logic hit;
		logic open;

		assign mode = plb_inmode_e'(in_cfg_r[j][PLB_IN_MODE_LSB +: 2]);
		assign csel = in_cfg_r[j][PLB_IN_CLK_LSB +: 2];
		assign hit = in_edge[csel];
		assign open = in_open[csel];

		always_comb begin
			s1_nxt = s1_r;
			s2_nxt = s2_r;
			unique case (mode)
				PLB_IN_COMB: s1_nxt = in_src[j];
				PLB_IN_REG: if (hit) s1_nxt = in_src[j];
				PLB_IN_DREG: begin
					if (hit) begin
						s1_nxt = in_src[j];
						s2_nxt = s1_r;
					end
				end
				PLB_IN_LATCH: if (open) s1_nxt = in_src[j];
			endcase
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				s1_r <= 1'b0;
				s2_r <= 1'b0;
			end else begin
				s1_r <= s1_nxt;
				s2_r <= s2_nxt;
			end
		end

		always_comb begin
			unique case (mode)
				PLB_IN_COMB: in_to_gim[j] = in_src[j];
				PLB_IN_REG: in_to_gim[j] = s1_r;
				PLB_IN_DREG: in_to_gim[j] = s2_r;
				PLB_IN_LATCH: in_to_gim[j] = open ? in_src[j] : s1_r;
			endcase
		end
	end
endmodule : plb_logic_block

// ---- testbench/plb_far_side.sv ----
module plb_far_side (
	input wire logic [plb_pkg::PLB_NUM_MC-1:0] io_out,
	input wire logic [plb_pkg::PLB_NUM_MC-1:0] io_oe,
	output logic [plb_pkg::PLB_NUM_GIM-1:0] gim_in,
	output logic [plb_pkg::PLB_NUM_MC-1:0] io_in,
	output logic [plb_pkg::PLB_NUM_DED-1:0] ded_pin,
	output logic [plb_pkg::PLB_NUM_ICLK-1:0] ic_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	import plb_pkg::*;
	// levels set by the bench at rising edges
	logic [PLB_NUM_GIM-1:0] gim_r = 36'h8_0000_0000;
	logic [PLB_NUM_MC-1:0] ext_r = 16'h0;
	logic [PLB_NUM_DED-1:0] ded_r = 2'h0;
	logic [PLB_NUM_ICLK-1:0] ic_r = 4'h0;
	assign gim_in = gim_r;
	assign ded_pin = ded_r;
	assign ic_pin = ic_r;
	// pin wire: block wins where it drives, board elsewhere
	assign io_in = (io_oe & io_out) | (~io_oe & ext_r);
endmodule : plb_far_side

// ---- testbench/plb_logic_block_chk.sv ----
module plb_logic_block_chk #(
	parameter bit REG_INTENSIVE = 1'b0,
	parameter bit FOUR_CLOCKS = 1'b1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [plb_pkg::PLB_NUM_GIM-1:0] gim_in,
	input wire logic [plb_pkg::PLB_NUM_MC-1:0] io_in,
	input wire logic [plb_pkg::PLB_NUM_MC-1:0] io_out,
	input wire logic [plb_pkg::PLB_NUM_MC-1:0] io_oe,
	input wire logic [plb_pkg::PLB_NUM_DED-1:0] ded_pin,
	input wire logic [plb_pkg::PLB_NUM_ICLK-1:0] ic_pin,
	input wire logic [plb_pkg::PLB_NUM_ICLK-1:0] gclk_out,
	input wire logic [plb_pkg::PLB_NUM_MC-1:0] mc_to_gim,
	input wire logic [plb_pkg::PLB_NUM_MC-1:0] pin_to_gim,
	input wire logic [plb_pkg::PLB_NUM_INCELL-1:0] in_to_gim
);
	timeunit 1ns;
	timeprecision 100ps;
	import plb_pkg::*;
	localparam logic [15:0] BURIED = REG_INTENSIVE ? 16'haaaa : 16'h0000;
	localparam logic [3:0] LIVE_CLK = FOUR_CLOCKS ? 4'hf : 4'h3;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ****************************************
	// sequences
	// ****************************************
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_stat_setup;
		psel && !penable && !pwrite && paddr == PLB_STAT;
	endsequence
	// ****************************************
	// assertions
	// ****************************************
	a_ready_access: assert property (s_access |-> pready)
		else $error("pready low in access phase");
	a_err_phase: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access phase");
	a_err_read_zero: assert property ((s_access ##0 (pslverr && !pwrite)) |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_stat_write_err: assert property ((s_access ##0 (pwrite && paddr == PLB_STAT)) |-> pslverr)
		else $error("status write not refused");
	a_misalign_err: assert property ((s_access ##0 (paddr[1:0] != 2'h0)) |-> pslverr)
		else $error("misaligned access not refused");
	a_stat_mirror: assert property (s_stat_setup |=> prdata[15:0] == $past(mc_to_gim)
		&& prdata[21:16] == $past(in_to_gim))
		else $error("status does not mirror feedback");
	a_buried_quiet: assert property (((io_oe | io_out) & BURIED) == 16'h0)
		else $error("buried cell reached a pin");
	a_pin_feed: assert property (pin_to_gim == (io_in & ~BURIED))
		else $error("pin input path wrong");
	a_clock_mask: assert property (gclk_out == (ic_pin & LIVE_CLK))
		else $error("clock distribution wrong");
	a_reset_quiet: assert property ($rose(presetn) |-> io_oe == 16'h0 && mc_to_gim == 16'h0)
		else $error("outputs active right after reset");
endmodule : plb_logic_block_chk

bind plb_logic_block plb_logic_block_chk #(.REG_INTENSIVE(REG_INTENSIVE),
	.FOUR_CLOCKS(FOUR_CLOCKS)) u_plb_logic_block_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gim_in, .io_in, .io_out, .io_oe,
	.ded_pin, .ic_pin, .gclk_out, .mc_to_gim, .pin_to_gim, .in_to_gim);

// ---- testbench/plb_logic_block_bench.sv ----
module plb_logic_block_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import plb_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [PLB_NUM_GIM-1:0] gim_in;
	logic [PLB_NUM_MC-1:0] io_in, io_out, io_oe, mc_to_gim, pin_to_gim;
	logic [PLB_NUM_DED-1:0] ded_pin;
	logic [PLB_NUM_ICLK-1:0] ic_pin, gclk_out;
	logic [PLB_NUM_INCELL-1:0] in_to_gim;
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [31:0] q;
	logic e;

	always #20 pclk = ~pclk;

	// register-intensive variant reaches buried cells and input registers
	plb_logic_block #(.REG_INTENSIVE(1'b1), .FOUR_CLOCKS(1'b1)) u_plb_logic_block (.pclk,
		.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.gim_in, .io_in, .io_out, .io_oe, .ded_pin, .ic_pin, .gclk_out, .mc_to_gim,
		.pin_to_gim, .in_to_gim);
	plb_far_side u_plb_far_side (.io_out, .io_oe, .gim_in, .io_in, .ded_pin, .ic_pin);

	// ****************************************
	// tasks
	// ****************************************
	task close_out;
		if (mismatches == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// one spare edge so the write has landed before anyone looks
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		@(posedge pclk);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp);
		chk(32'(e), 32'h0);
	endtask : rd

	task g(input int i, input logic v);
		@(posedge pclk);
		u_plb_far_side.gim_r[i] <= v;
		repeat (2) @(posedge pclk);
	endtask : g

	task tick(input int k, input logic v);
		@(posedge pclk);
		u_plb_far_side.ic_r[k] <= v;
		repeat (3) @(posedge pclk);
	endtask : tick

	task obs(input int i, input logic [1:0] exp);
		chk({30'h0, io_out[i], mc_to_gim[i]}, {30'h0, exp});
	endtask : obs

	function automatic logic [11:0] pt(input int t, input int w);
		return 12'(t * 16 + w * 4);
	endfunction : pt

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 6000) begin
			mismatches++;
			close_out();
		end
	end

	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(PLB_CTRL, 32'h0);
		rd(PLB_MC_BASE + 12'h3c, 32'h0);
		rd(PLB_IN_BASE + 12'h14, 32'h0);
		apb(1'b1, PLB_STAT, 32'h1);
		chk(32'(e), 32'h1);
		apb(1'b0, 12'h700, 32'h0);
		chk({q[30:0], e}, 32'h1);
		apb(1'b1, PLB_MC_BASE + 12'h2, 32'h3);
		chk(32'(e), 32'h1);
		rd(PLB_MC_BASE, 32'h0);
		wr(pt(0, 0), 32'h1);
		wr(pt(1, 3), 32'h8);
		wr(PLB_MC_BASE, 32'h3);
		rd(PLB_MC_BASE, 32'h3);
		obs(0, 2'b00);
		g(0, 1'b1);
		obs(0, 2'b11);
		g(0, 1'b0);
		g(35, 1'b0);
		obs(0, 2'b11);
		g(35, 1'b1);
		wr(PLB_MC_BASE, 32'h0010_0003);
		obs(0, 2'b10);
		wr(pt(80, 0), 32'h2);
		wr(pt(81, 0), 32'h4);
		g(1, 1'b1);
		for (int m = 0; m < 4; m++) begin
			wr(PLB_MC_BASE, 32'(m << 22) | 32'h3);
			chk(32'(io_oe[0]), 32'(m == 1 || m == 2));
		end
		wr(pt(82, 0), 32'h8);
		g(1, 1'b0);
		g(3, 1'b1);
		wr(PLB_MC_BASE + 12'h20, 32'h0080_0000);
		chk(32'(io_oe[8]), 32'h1);
		wr(pt(10, 0), 32'h10);
		wr(PLB_MC_BASE + 12'h8, 32'h0001_0001);
		g(4, 1'b1);
		tick(0, 1'b1);
		obs(2, 2'b11);
		g(4, 1'b0);
		tick(0, 1'b0);
		obs(2, 2'b11);
		tick(0, 1'b1);
		obs(2, 2'b00);
		wr(PLB_MC_BASE + 12'h8, 32'h0002_0001);
		g(4, 1'b1);
		tick(0, 1'b0);
		obs(2, 2'b00);
		tick(0, 1'b1);
		obs(2, 2'b11);
		wr(PLB_CTRL, 32'h4);
		wr(PLB_IN_BASE, 32'h1);
		@(posedge pclk);
		u_plb_far_side.ded_r[0] <= 1'b1;
		tick(0, 1'b0);
		obs(2, 2'b00);
		chk(32'(in_to_gim[0]), 32'h0);
		tick(0, 1'b1);
		obs(2, 2'b00);
		chk(32'(in_to_gim[0]), 32'h1);
		wr(pt(84, 0), 32'h80);
		wr(pt(85, 0), 32'h40);
		g(7, 1'b1);
		obs(2, 2'b11);
		apb(1'b0, PLB_STAT, 32'h0);
		chk(32'(q[23:22]), 32'h1);
		g(7, 1'b0);
		g(6, 1'b1);
		obs(2, 2'b00);
		apb(1'b0, PLB_STAT, 32'h0);
		chk(32'(q[23:22]), 32'h2);
		g(6, 1'b0);
		wr(PLB_CTRL, 32'h5);
		obs(2, 2'b11);
		g(7, 1'b1);
		apb(1'b0, PLB_STAT, 32'h0);
		chk(32'(q[23:22]), 32'h0);
		wr(PLB_IN_BASE + 12'h4, 32'h6);
		@(posedge pclk);
		u_plb_far_side.ded_r[1] <= 1'b1;
		tick(1, 1'b1);
		chk(32'(in_to_gim[1]), 32'h0);
		tick(1, 1'b0);
		tick(1, 1'b1);
		chk(32'(in_to_gim[1]), 32'h1);
		wr(PLB_MC_BASE, 32'h3);
		@(posedge pclk);
		u_plb_far_side.ext_r[0] <= 1'b1;
		wr(PLB_MC_BASE + 12'h4, 32'h0021_0000);
		tick(0, 1'b0);
		chk(32'(mc_to_gim[1]), 32'h1);
		chk(32'(pin_to_gim[0]), 32'h1);
		chk(32'(io_out[1] | io_oe[1]), 32'h0);
		wr(pt(15, 0), 32'h100);
		wr(PLB_MC_BASE + 12'h8, 32'h20);
		wr(PLB_MC_BASE + 12'hc, 32'h1);
		g(8, 1'b1);
		chk(32'(mc_to_gim[3:2]), 32'h3);
		g(8, 1'b0);
		chk(32'(mc_to_gim[3:2]), 32'h0);
		// last general term, reached only by the top window
		wr(pt(79, 0), 32'h200);
		wr(PLB_MC_BASE + 12'h3c, 32'h8000);
		g(9, 1'b1);
		chk(32'(mc_to_gim[15]), 32'h1);
		// reset in mid-run must clear live configuration
		wr(PLB_MC_BASE, 32'h0040_0003);
		chk(32'(io_oe[0]), 32'h1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk(32'(io_oe[0]), 32'h0);
		chk(32'(mc_to_gim[15]), 32'h0);
		rd(PLB_MC_BASE, 32'h0);
		close_out();
	end
endmodule : plb_logic_block_bench
